// File: inc/csspc_pkg.sv
// package: opcodes, register map, field codes and carriers of the css command block
package csspc_pkg;
  // command opcodes
  localparam logic [7:0] STANDBY_COMMAND = 8'h01;
  localparam logic [7:0] PACKET_KIND_COMMAND = 8'h02;
  localparam logic [7:0] CARRIER_FREQ_COMMAND = 8'h03;
  localparam logic [7:0] BUFFER_BASES_COMMAND = 8'h04;
  localparam logic [7:0] MODULATION_COMMAND = 8'h05;
  localparam logic [7:0] PACKET_FORMAT_COMMAND = 8'h06;
  localparam logic [7:0] REGISTER_WRITE_COMMAND = 8'h07;
  localparam logic [7:0] REGISTER_READ_COMMAND = 8'h08;
  localparam logic [7:0] BUFFER_WRITE_COMMAND = 8'h09;
  localparam logic [7:0] BUFFER_READ_COMMAND = 8'h0a;
  localparam logic [7:0] DIO_IRQ_COMMAND = 8'h0b;
  localparam logic [7:0] IRQ_STATUS_COMMAND = 8'h0c;
  localparam logic [7:0] IRQ_CLEAR_COMMAND = 8'h0d;
  localparam logic [7:0] RX_BUFFER_INFO_COMMAND = 8'h0e;
  localparam logic [7:0] PACKET_STATUS_COMMAND = 8'h0f;
  // register map and reset value
  localparam logic [15:0] ADDR_SF_DEPENDENT_TUNING = 16'h0925;
  localparam logic [15:0] ADDR_FREQ_ERROR_COMP_MODE = 16'h093c;
  localparam logic [15:0] ADDR_SYNC_WORD_HIGH_NIBBLE = 16'h0944;
  localparam logic [15:0] ADDR_SYNC_WORD_LOW_NIBBLE = 16'h0945;
  localparam logic [7:0] RST_TUNING_REG = 8'h00;
  // argument codes
  localparam logic [7:0] CSS_PACKET_KIND = 8'h01;
  localparam logic [7:0] SPREAD_FACTOR_FIVE_CODE = 8'h50;
  localparam logic [7:0] SPREAD_FACTOR_TWELVE_CODE = 8'hc0;
  localparam logic [7:0] WIDEST_BANDWIDTH_CODE = 8'h0a;
  localparam logic [7:0] BW_812_CODE = 8'h18;
  localparam logic [7:0] BW_406_CODE = 8'h26;
  localparam logic [7:0] BW_203_CODE = 8'h34;
  localparam logic [7:0] CR_FIRST_CODE = 8'h01;
  localparam logic [7:0] CR_LONG_FIRST_CODE = 8'h05;
  localparam logic [7:0] LONG_INTERLEAVE_HALF_RATE = 8'h07;
  localparam logic [7:0] HDR_EXPLICIT_CODE = 8'h00;
  localparam logic [7:0] HDR_IMPLICIT_CODE = 8'h80;
  localparam logic [7:0] CRC_ON_CODE = 8'h20;
  localparam logic [7:0] CRC_OFF_CODE = 8'h00;
  localparam logic [7:0] IQ_SWAPPED_CODE = 8'h00;
  localparam logic [7:0] IQ_NORMAL_CODE = 8'h40;
  // pll step is PLL_REF_HZ / 2**PLL_STEP_LOG2 per lsb of the frequency word
  localparam int PLL_REF_HZ = 52000000;
  localparam int PLL_STEP_LOG2 = 18;
  // timing counts in clock cycles
  localparam int CAL_CYCLES = 256;
  localparam int CMD_BUSY_CYCLES = 4;
  // interrupt flag positions
  localparam int IRQ_TX_DONE = 0;
  localparam int IRQ_RX_DONE = 1;
  localparam int IRQ_SYNC_VALID = 2;
  localparam int IRQ_HDR_VALID = 4;
  localparam int IRQ_HDR_ERR = 5;
  localparam int IRQ_CRC_ERR = 6;
  localparam int IRQ_PREAMBLE = 7;
  localparam int IRQ_TIMEOUT = 14;
  // modem events, one-cycle pulses
  typedef struct packed {
    logic tx_done;
    logic rx_done;
    logic pkt_iq_swapped;
    logic sync_valid;
    logic [2:0] sync_code;
    logic hdr_valid;
    logic hdr_err;
    logic crc_err;
    logic preamble;
    logic timeout;
  } csspc_evt_t;
  // modem configuration
  typedef struct packed {
    logic css_packet_kind;
    logic [23:0] carrier_freq_word;
    logic [7:0] tx_buffer_base;
    logic [7:0] rx_buffer_base;
    logic [3:0] spread_factor;
    logic [1:0] bw_index;
    logic [2:0] coding_rate;
    logic long_interleave;
    logic cr_in_header;
    logic scramble;
    logic [18:0] preamble_syms;
    logic implicit_hdr;
    logic [7:0] payload_len;
    logic crc_on;
    logic iq_swapped;
    logic mod_err;
    logic fmt_err;
  } csspc_cfg_t;
endpackage

// File: hw/csspc_core.sv
`timescale 1ns/1ps
// css modem command interpreter: configuration, status, irq/dio and data buffer
module csspc_core #(
  parameter int BUF_DEPTH = 256,
  parameter int CAL_LEN = csspc_pkg::CAL_CYCLES,
  parameter int CMD_BUSY_LEN = csspc_pkg::CMD_BUSY_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // host command port
  input wire logic cmd_frame,
  input wire logic cmd_byte_valid,
  input wire logic [7:0] cmd_byte,
  output logic [7:0] rsp_byte,
  output logic busy,
  // modem side
  input wire csspc_pkg::csspc_evt_t evt,
  input wire logic [7:0] rssi_sync,
  input wire logic rx_wr_valid,
  input wire logic [7:0] rx_wr_data,
  input wire logic tx_rd_req,
  input wire logic [7:0] tx_rd_idx,
  output logic [7:0] tx_rd_data,
  // configuration and status
  output csspc_pkg::csspc_cfg_t cfg,
  output logic [7:0] sf_dependent_tuning,
  output logic [7:0] freq_error_comp_mode,
  output logic [7:0] sync_word,
  output logic [2:0] dio,
  output logic tx_complete_flag,
  output logic [2:0] matched_sync_index
);
  import csspc_pkg::*;

  localparam int AW = $clog2(BUF_DEPTH);
  typedef enum logic [1:0] {ST_CAL = 2'b00, ST_READY = 2'b01, ST_BUSY = 2'b10} csspc_state_t;

  csspc_state_t state_ff, nxt_state;
  logic [15:0] cnt_ff, nxt_cnt;
  logic busy_ff, frame_q_ff, frame_ok_ff, frame_ok, frame_rise, take, frame_end;
  logic [7:0] idx_ff, opcode_ff, op, pos, status_byte, rsp_ff, nxt_rsp, reg_rd;
  logic [7:0] arg_ff [1:8];
  logic [15:0] ptr_ff;
  logic [7:0] mem [0:BUF_DEPTH-1];
  logic [7:0] sf_dependent_tuning_ff, freq_error_comp_mode_ff;
  logic [7:0] sync_word_high_nibble_ff, sync_word_low_nibble_ff;
  logic [15:0] irq_flags_ff, irq_en_ff, irq_raw, irq_set, irq_clr, nxt_irq_flags;
  logic [15:0] dio_map_ff [0:2];
  logic [2:0] dio_ff, matched_sync_index_ff;
  logic tx_complete_flag_ff, rx_accept;
  logic [7:0] rx_cnt_ff, rx_payload_size_ff, rx_payload_start_ff, tx_rd_data_ff;
  csspc_cfg_t cfg_ff;
  logic sf_ok, bw_ok, cr_ok, fmt_ok;
  logic [1:0] bw_idx;

  // outputs straight from flops
  assign rsp_byte = rsp_ff;
  assign busy = busy_ff;
  assign tx_rd_data = tx_rd_data_ff;
  assign cfg = cfg_ff;
  assign sf_dependent_tuning = sf_dependent_tuning_ff;
  assign freq_error_comp_mode = freq_error_comp_mode_ff;
  assign sync_word = {sync_word_high_nibble_ff[7:4], sync_word_low_nibble_ff[7:4]};
  assign dio = dio_ff;
  assign tx_complete_flag = tx_complete_flag_ff;
  assign matched_sync_index = matched_sync_index_ff;

  // a frame opened while busy is ignored whole, so half commands never execute
  assign frame_rise = cmd_frame & ~frame_q_ff;
  assign frame_ok = frame_rise ? (state_ff == ST_READY) : frame_ok_ff;
  assign take = cmd_byte_valid & cmd_frame & frame_ok;
  assign frame_end = frame_q_ff & ~cmd_frame & frame_ok_ff & (idx_ff != 8'h00);
  assign op = (idx_ff == 8'h00) ? cmd_byte : opcode_ff;
  assign pos = idx_ff + 8'h01;
  assign status_byte = {5'h00, 2'(state_ff), cfg_ff.mod_err | cfg_ff.fmt_err};

  // power-up calibration, then rc standby; busy after each command
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 16'h0001;
    unique case (state_ff)
      ST_CAL: if (cnt_ff == 16'(CAL_LEN - 1)) nxt_state = ST_READY;
      ST_READY: begin
        nxt_cnt = 16'h0000;
        if (frame_end) nxt_state = ST_BUSY;
      end
      ST_BUSY: if (cnt_ff == 16'(CMD_BUSY_LEN - 1)) nxt_state = ST_READY;
      default: nxt_state = ST_CAL;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= ST_CAL;
      cnt_ff <= 16'h0000;
      busy_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      busy_ff <= (nxt_state != ST_READY);
    end
  end

  // byte position and argument capture
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frame_q_ff <= 1'b0;
      frame_ok_ff <= 1'b0;
      idx_ff <= 8'h00;
      opcode_ff <= 8'h00;
      for (int i = 1; i <= 8; i++) arg_ff[i] <= 8'h00;
    end else begin
      frame_q_ff <= cmd_frame;
      frame_ok_ff <= cmd_frame & frame_ok;
      if (!cmd_frame) idx_ff <= 8'h00;
      else if (take && idx_ff != 8'hff) idx_ff <= pos;
      if (take && idx_ff == 8'h00) opcode_ff <= cmd_byte;
      if (take && idx_ff >= 8'h01 && idx_ff <= 8'h08) arg_ff[idx_ff[3:0]] <= cmd_byte;
    end
  end

  // argument checks
  assign sf_ok = (arg_ff[1][3:0] == 4'h0) && (arg_ff[1] >= SPREAD_FACTOR_FIVE_CODE) &&
                 (arg_ff[1] <= SPREAD_FACTOR_TWELVE_CODE);
  assign cr_ok = (arg_ff[3] >= CR_FIRST_CODE) && (arg_ff[3] <= LONG_INTERLEAVE_HALF_RATE);
  assign fmt_ok = (arg_ff[1][3:0] != 4'h0) && (arg_ff[1][7:4] != 4'h0) &&
                  (arg_ff[2] == HDR_EXPLICIT_CODE || arg_ff[2] == HDR_IMPLICIT_CODE) &&
                  (arg_ff[3] != 8'h00) &&
                  (arg_ff[4] == CRC_ON_CODE || arg_ff[4] == CRC_OFF_CODE) &&
                  (arg_ff[5] == IQ_SWAPPED_CODE || arg_ff[5] == IQ_NORMAL_CODE);

  always_comb begin
    bw_ok = 1'b1;
    bw_idx = 2'h0;
    case (arg_ff[2])
      WIDEST_BANDWIDTH_CODE: bw_idx = 2'h0;
      BW_812_CODE: bw_idx = 2'h1;
      BW_406_CODE: bw_idx = 2'h2;
      BW_203_CODE: bw_idx = 2'h3;
      default: bw_ok = 1'b0;
    endcase
  end

  // configuration commands take effect when the frame closes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_ff <= '0;
    end else if (frame_end) begin
      case (opcode_ff)
        PACKET_KIND_COMMAND: cfg_ff.css_packet_kind <= (arg_ff[1] == CSS_PACKET_KIND);
        CARRIER_FREQ_COMMAND: cfg_ff.carrier_freq_word <= {arg_ff[1], arg_ff[2], arg_ff[3]};
        BUFFER_BASES_COMMAND: begin
          cfg_ff.tx_buffer_base <= arg_ff[1];
          cfg_ff.rx_buffer_base <= arg_ff[2];
        end
        MODULATION_COMMAND: begin
          cfg_ff.mod_err <= !(sf_ok && bw_ok && cr_ok);
          if (sf_ok && bw_ok && cr_ok) begin
            cfg_ff.spread_factor <= arg_ff[1][7:4];
            cfg_ff.bw_index <= bw_idx;
            cfg_ff.coding_rate <= arg_ff[3][2:0];
            // long interleave keeps the fec, signals cr in header, scrambles; implicit header allowed
            cfg_ff.long_interleave <= (arg_ff[3] >= CR_LONG_FIRST_CODE);
            cfg_ff.cr_in_header <= (arg_ff[3] >= CR_LONG_FIRST_CODE);
            cfg_ff.scramble <= 1'b1;
          end
        end
        PACKET_FORMAT_COMMAND: begin
          cfg_ff.fmt_err <= !fmt_ok;
          if (fmt_ok) begin
            cfg_ff.preamble_syms <= 19'(arg_ff[1][3:0]) << arg_ff[1][7:4];
            cfg_ff.implicit_hdr <= (arg_ff[2] == HDR_IMPLICIT_CODE);
            cfg_ff.payload_len <= arg_ff[3];
            cfg_ff.crc_on <= (arg_ff[4] == CRC_ON_CODE);
            cfg_ff.iq_swapped <= (arg_ff[5] == IQ_SWAPPED_CODE);
          end
        end
        default: ;
      endcase
    end
  end

  // register/buffer pointer, auto-incremented per data byte
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ptr_ff <= 16'h0000;
    end else if (take) begin
      if ((op == REGISTER_WRITE_COMMAND || op == REGISTER_READ_COMMAND) && idx_ff == 8'h01) ptr_ff[15:8] <= cmd_byte;
      else if ((op == REGISTER_WRITE_COMMAND || op == REGISTER_READ_COMMAND) && idx_ff == 8'h02)
        ptr_ff[7:0] <= cmd_byte;
      else if ((op == BUFFER_WRITE_COMMAND || op == BUFFER_READ_COMMAND) && idx_ff == 8'h01) ptr_ff <= {8'h00, cmd_byte};
      else if (((op == REGISTER_WRITE_COMMAND || op == REGISTER_READ_COMMAND) && idx_ff >= 8'h03) ||
               ((op == BUFFER_WRITE_COMMAND || op == BUFFER_READ_COMMAND) && idx_ff >= 8'h02))
        ptr_ff <= (op == BUFFER_WRITE_COMMAND || op == BUFFER_READ_COMMAND) ?
                  {8'h00, 8'(ptr_ff[7:0] + 8'h01)} : ptr_ff + 16'h0001;
    end
  end

  // tuning registers keep all eight bits so host read-modify-write works
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sf_dependent_tuning_ff <= RST_TUNING_REG;
      freq_error_comp_mode_ff <= RST_TUNING_REG;
      sync_word_high_nibble_ff <= RST_TUNING_REG;
      sync_word_low_nibble_ff <= RST_TUNING_REG;
    end else if (take && opcode_ff == REGISTER_WRITE_COMMAND && idx_ff >= 8'h03) begin
      case (ptr_ff)
        ADDR_SF_DEPENDENT_TUNING: sf_dependent_tuning_ff <= cmd_byte;
        ADDR_FREQ_ERROR_COMP_MODE: freq_error_comp_mode_ff <= cmd_byte;
        ADDR_SYNC_WORD_HIGH_NIBBLE: sync_word_high_nibble_ff <= cmd_byte;
        ADDR_SYNC_WORD_LOW_NIBBLE: sync_word_low_nibble_ff <= cmd_byte;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (ptr_ff)
      ADDR_SF_DEPENDENT_TUNING: reg_rd = sf_dependent_tuning_ff;
      ADDR_FREQ_ERROR_COMP_MODE: reg_rd = freq_error_comp_mode_ff;
      ADDR_SYNC_WORD_HIGH_NIBBLE: reg_rd = sync_word_high_nibble_ff;
      ADDR_SYNC_WORD_LOW_NIBBLE: reg_rd = sync_word_low_nibble_ff;
      default: reg_rd = 8'h00;
    endcase
  end

  // data buffer: host writes and modem receive stream; no reset on storage
  always_ff @(posedge clock) begin
    if (take && opcode_ff == BUFFER_WRITE_COMMAND && idx_ff >= 8'h02) mem[AW'(ptr_ff[7:0])] <= cmd_byte;
    if (rx_wr_valid) mem[AW'(8'(cfg_ff.rx_buffer_base + rx_cnt_ff))] <= rx_wr_data;
  end

  // modem transmit fetch, relative to the tx base
  always_ff @(posedge clock) begin
    if (sys_rst) tx_rd_data_ff <= 8'h00;
    else if (tx_rd_req) tx_rd_data_ff <= mem[AW'(8'(cfg_ff.tx_buffer_base + tx_rd_idx))];
  end

  // receive bookkeeping; a packet with the other iq sense is dropped
  assign rx_accept = evt.rx_done & (evt.pkt_iq_swapped == cfg_ff.iq_swapped);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_cnt_ff <= 8'h00;
      rx_payload_size_ff <= 8'h00;
      rx_payload_start_ff <= 8'h00;
    end else begin
      if (evt.rx_done) rx_cnt_ff <= 8'h00;
      else if (rx_wr_valid) rx_cnt_ff <= rx_cnt_ff + 8'h01;
      if (rx_accept) begin
        rx_payload_size_ff <= rx_cnt_ff + {7'h00, rx_wr_valid};
        rx_payload_start_ff <= cfg_ff.rx_buffer_base;
      end
    end
  end

  // interrupt flags: set wins over a clear in the same cycle
  always_comb begin
    irq_raw = 16'h0000;
    irq_raw[IRQ_TX_DONE] = evt.tx_done;
    irq_raw[IRQ_RX_DONE] = rx_accept;
    irq_raw[IRQ_SYNC_VALID] = evt.sync_valid;
    irq_raw[IRQ_HDR_VALID] = evt.hdr_valid;
    irq_raw[IRQ_HDR_ERR] = evt.hdr_err;
    irq_raw[IRQ_CRC_ERR] = evt.crc_err;
    irq_raw[IRQ_PREAMBLE] = evt.preamble;
    irq_raw[IRQ_TIMEOUT] = evt.timeout;
  end
  assign irq_set = irq_raw & irq_en_ff;
  assign irq_clr = (frame_end && opcode_ff == IRQ_CLEAR_COMMAND) ? {arg_ff[1], arg_ff[2]} : 16'h0000;
  assign nxt_irq_flags = (irq_flags_ff & ~irq_clr) | irq_set;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_flags_ff <= 16'h0000;
      irq_en_ff <= 16'h0000;
      for (int i = 0; i < 3; i++) dio_map_ff[i] <= 16'h0000;
    end else begin
      irq_flags_ff <= nxt_irq_flags;
      if (frame_end && opcode_ff == DIO_IRQ_COMMAND) begin
        irq_en_ff <= {arg_ff[1], arg_ff[2]};
        dio_map_ff[0] <= {arg_ff[3], arg_ff[4]};
        dio_map_ff[1] <= {arg_ff[5], arg_ff[6]};
        dio_map_ff[2] <= {arg_ff[7], arg_ff[8]};
      end
    end
  end

  // each dio is the or of its mapped flags, from next flag values
  for (genvar g = 0; g < 3; g++) begin : g_dio
    always_ff @(posedge clock) begin
      if (sys_rst) dio_ff[g] <= 1'b0;
      else dio_ff[g] <= |(nxt_irq_flags & dio_map_ff[g]);
    end
  end

  // packet status bits
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_complete_flag_ff <= 1'b0;
      matched_sync_index_ff <= 3'h0;
    end else begin
      if (evt.tx_done) tx_complete_flag_ff <= 1'b1;
      else if (irq_clr[IRQ_TX_DONE]) tx_complete_flag_ff <= 1'b0;
      if (evt.sync_valid) matched_sync_index_ff <= evt.sync_code;
    end
  end

  // response byte for the next position of the frame
  always_comb begin
    nxt_rsp = status_byte;
    case (op)
      IRQ_STATUS_COMMAND: if (pos == 8'h01) nxt_rsp = irq_flags_ff[15:8];
                          else if (pos == 8'h02) nxt_rsp = irq_flags_ff[7:0];
      RX_BUFFER_INFO_COMMAND: if (pos == 8'h01) nxt_rsp = rx_payload_size_ff;
                              else if (pos == 8'h02) nxt_rsp = rx_payload_start_ff;
      PACKET_STATUS_COMMAND: if (pos == 8'h01) nxt_rsp = rssi_sync;
                             else if (pos == 8'h03) nxt_rsp = {7'h00, tx_complete_flag_ff};
                             else if (pos == 8'h04) nxt_rsp = {5'h00, matched_sync_index_ff};
                             else if (pos == 8'h02 || pos == 8'h05) nxt_rsp = 8'h00;
      REGISTER_READ_COMMAND: if (pos >= 8'h04) nxt_rsp = reg_rd;
      BUFFER_READ_COMMAND: if (pos >= 8'h03) nxt_rsp = mem[AW'(ptr_ff[7:0])];
      default: ;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) rsp_ff <= 8'h00;
    else if (!cmd_frame) rsp_ff <= status_byte;
    else if (take) rsp_ff <= nxt_rsp;
  end

  // checks
  a_tx_done_flag: assert property (@(posedge clock) disable iff (sys_rst)
    evt.tx_done |=> tx_complete_flag_ff) else $error("tx complete flag not set");
  a_sync_index_latch: assert property (@(posedge clock) disable iff (sys_rst)
    evt.sync_valid |=> matched_sync_index_ff == $past(evt.sync_code)) else $error("sync index wrong");
  a_irq_clear_exact: assert property (@(posedge clock) disable iff (sys_rst)
    (irq_clr != 16'h0000) |=> ((irq_flags_ff & $past(irq_clr) & ~$past(irq_set)) == 16'h0000) &&
    ((irq_flags_ff & ~$past(irq_clr)) == (($past(irq_flags_ff) | $past(irq_set)) & ~$past(irq_clr))))
    else $error("irq clear touched wrong flags");
  a_dio_low_clear: assert property (@(posedge clock) disable iff (sys_rst)
    (irq_flags_ff == 16'h0000) |-> (dio_ff == 3'b000)) else $error("dio high with no flags");
  a_rx_info_start: assert property (@(posedge clock) disable iff (sys_rst)
    rx_accept |=> rx_payload_start_ff == $past(cfg_ff.rx_buffer_base)) else $error("rx start wrong");
  a_cal_busy_hold: assert property (@(posedge clock)
    $fell(sys_rst) |-> busy_ff [*8]) else $error("busy dropped during calibration");
  a_cal_busy_end: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == ST_CAL && cnt_ff == 16'(CAL_LEN - 1)) |=> !busy_ff) else $error("busy stuck after calibration");
  a_sf_code_map: assert property (@(posedge clock) disable iff (sys_rst)
    (frame_end && opcode_ff == MODULATION_COMMAND && sf_ok && bw_ok && cr_ok) |=>
    cfg_ff.spread_factor == $past(arg_ff[1][7:4]) && cfg_ff.spread_factor >= 4'h5 && cfg_ff.spread_factor <= 4'hc)
    else $error("spreading factor not taken");
  a_bw_narrow_code: assert property (@(posedge clock) disable iff (sys_rst)
    (frame_end && opcode_ff == MODULATION_COMMAND && sf_ok && cr_ok && arg_ff[2] == BW_203_CODE) |=>
    cfg_ff.bw_index == 2'h3 && !cfg_ff.mod_err) else $error("bandwidth code wrong");
  a_cr_invalid: assert property (@(posedge clock) disable iff (sys_rst)
    (frame_end && opcode_ff == MODULATION_COMMAND && (arg_ff[3] == 8'h00 || arg_ff[3] > 8'h07)) |=>
    cfg_ff.mod_err && $stable(cfg_ff.coding_rate)) else $error("bad coding rate accepted");
  a_preamble_len: assert property (@(posedge clock) disable iff (sys_rst)
    (frame_end && opcode_ff == PACKET_FORMAT_COMMAND && fmt_ok) |=>
    cfg_ff.preamble_syms == (19'($past(arg_ff[1][3:0])) << $past(arg_ff[1][7:4]))) else $error("preamble wrong");
  a_iq_reject: assert property (@(posedge clock) disable iff (sys_rst)
    (evt.rx_done && evt.pkt_iq_swapped != cfg_ff.iq_swapped && !irq_flags_ff[IRQ_RX_DONE]) |=>
    !irq_flags_ff[IRQ_RX_DONE]) else $error("iq mismatched packet detected");
endmodule

// File: verification/csspc_host.sv
// host model: frames commands on the device command port
`timescale 1ns/1ps
module csspc_host (
  // clock
  input wire logic clock,
  // command port
  output logic cmd_frame,
  output logic cmd_byte_valid,
  output logic [7:0] cmd_byte,
  input wire logic [7:0] rsp_byte,
  input wire logic busy
);
  logic [7:0] r [16];
  // idle port at time zero
  initial begin
    cmd_frame = 1'b0;
    cmd_byte_valid = 1'b0;
    cmd_byte = 8'h00;
  end
  // one frame per call; r[i] is the answer to byte i+1
  task automatic run(input logic [7:0] b[$]);
    int k;
    k = 0;
    // busy is looked at mid-cycle, where it has settled
    @(negedge clock);
    while (busy !== 1'b0 && k < 2000) begin
      @(negedge clock);
      k++;
    end
    @(posedge clock);
    cmd_frame <= 1'b1;
    foreach (b[i]) begin
      @(posedge clock);
      cmd_byte_valid <= 1'b1;
      cmd_byte <= b[i];
      @(negedge clock);
      if (i > 0) r[i-1] = rsp_byte;
    end
    @(posedge clock);
    cmd_byte_valid <= 1'b0;
    cmd_frame <= 1'b0;
    // frame end executes one edge later
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask
endmodule

// File: verification/css_modem_packet_config_bench.sv
// bench: host frames commands, modem events driven directly
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module css_modem_packet_config_bench;
  import csspc_pkg::*;
  localparam int CAL = 16;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_frame, cmd_byte_valid, busy, tx_complete_flag;
  logic rx_wr_valid = 1'b0;
  logic tx_rd_req = 1'b0;
  logic [7:0] cmd_byte, rsp_byte, tx_rd_data, tuning, comp, sync_word;
  logic [7:0] rssi_sync = 8'h5c;
  logic [7:0] rx_wr_data = 8'h00;
  logic [7:0] tx_rd_idx = 8'h00;
  logic [7:0] z = 8'h00;
  logic [7:0] bwc [4] = '{8'h0a, 8'h18, 8'h26, 8'h34};
  logic [2:0] dio, matched_sync_index;
  csspc_evt_t evt = '0;
  csspc_evt_t ev;
  csspc_cfg_t cfg;
  int n_mismatch = 0;
  int comparisons = 0;
  // 4 ns period
  always #2 clock = ~clock;
  csspc_core #(.CAL_LEN(CAL)) dut_u (.clock(clock), .sys_rst(sys_rst), .cmd_frame(cmd_frame),
    .cmd_byte_valid(cmd_byte_valid), .cmd_byte(cmd_byte), .rsp_byte(rsp_byte), .busy(busy), .evt(evt),
    .rssi_sync(rssi_sync), .rx_wr_valid(rx_wr_valid), .rx_wr_data(rx_wr_data), .tx_rd_req(tx_rd_req),
    .tx_rd_idx(tx_rd_idx), .tx_rd_data(tx_rd_data), .cfg(cfg), .sf_dependent_tuning(tuning),
    .freq_error_comp_mode(comp), .sync_word(sync_word), .dio(dio), .tx_complete_flag(tx_complete_flag),
    .matched_sync_index(matched_sync_index));
  csspc_host host_u (.clock(clock), .cmd_frame(cmd_frame), .cmd_byte_valid(cmd_byte_valid),
    .cmd_byte(cmd_byte), .rsp_byte(rsp_byte), .busy(busy));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic regwr(input logic [15:0] a, input logic [7:0] d);
    host_u.run('{REGISTER_WRITE_COMMAND, a[15:8], a[7:0], d});
  endtask
  // one-cycle modem event, then let flags and dio settle
  task automatic pulse(input csspc_evt_t e);
    @(posedge clock);
    evt <= e;
    @(posedge clock);
    evt <= '0;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask
  // watchdog, far beyond the expected few hundred cycles
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
  // test sequence
  initial begin
    logic [7:0] rd;
    int k;
    int s;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    `CHK(busy, 1'b1)
    k = 0;
    while (busy !== 1'b0 && k < 100) begin
      @(negedge clock);
      k++;
    end
    `CHK(k <= CAL + 2, 1'b1)
    $display("test reset done");
    host_u.run('{PACKET_KIND_COMMAND, CSS_PACKET_KIND});
    host_u.run('{CARRIER_FREQ_COMMAND, 8'h12, 8'h34, 8'h56});
    `CHK(cfg.carrier_freq_word, 24'h123456)
    host_u.run('{BUFFER_BASES_COMMAND, 8'h10, 8'h80});
    `CHK({cfg.tx_buffer_base, cfg.rx_buffer_base}, 16'h1080)
    // every spread factor, bandwidth and coding rate code
    for (s = 5; s <= 12; s++) begin
      host_u.run('{MODULATION_COMMAND, 8'(s * 16), bwc[s % 4], 8'(s % 7 + 1)});
      `CHK(cfg.spread_factor, 4'(s))
      `CHK(cfg.bw_index, 2'(s % 4))
      `CHK(cfg.coding_rate, 3'(s % 7 + 1))
      `CHK(cfg.long_interleave & cfg.scramble & cfg.cr_in_header, s % 7 >= 4)
      rd = s < 7 ? 8'h1e : s < 9 ? 8'h37 : 8'h32;
      regwr(ADDR_SF_DEPENDENT_TUNING, rd);
      `CHK(tuning, rd)
    end
    regwr(ADDR_FREQ_ERROR_COMP_MODE, 8'h01);
    `CHK(comp, 8'h01)
    host_u.run('{MODULATION_COMMAND, 8'hc0, 8'h34, 8'h07});
    `CHK({cfg.mod_err, cfg.coding_rate, cfg.long_interleave}, 5'h0f)
    host_u.run('{MODULATION_COMMAND, 8'h70, 8'h0a, 8'h08});
    `CHK({cfg.mod_err, cfg.spread_factor}, 5'h1c)
    `CHK(rsp_byte, 8'h05)
    host_u.run('{PACKET_FORMAT_COMMAND, 8'h23, HDR_IMPLICIT_CODE, 8'hfd, CRC_ON_CODE, IQ_SWAPPED_CODE});
    `CHK(cfg.preamble_syms, 19'd12)
    `CHK({cfg.implicit_hdr, cfg.payload_len}, 9'h1fd)
    `CHK({cfg.crc_on, cfg.iq_swapped}, 2'b11)
    // zero payload length is refused, fields kept
    host_u.run('{PACKET_FORMAT_COMMAND, 8'h23, HDR_EXPLICIT_CODE, z, CRC_OFF_CODE, IQ_NORMAL_CODE});
    `CHK({cfg.fmt_err, cfg.implicit_hdr, cfg.payload_len, cfg.iq_swapped}, 11'h7fb)
    // low nibbles preloaded so the read-modify-write must keep them
    regwr(ADDR_SYNC_WORD_HIGH_NIBBLE, 8'h0a);
    regwr(ADDR_SYNC_WORD_LOW_NIBBLE, 8'h05);
    // sync word nibbles by read-modify-write
    for (s = 0; s < 2; s++) begin
      host_u.run('{REGISTER_READ_COMMAND, 8'h09, 8'(8'h44 + s), z, z});
      rd = host_u.r[3];
      regwr(16'(16'h0944 + s), {4'(3 + s), rd[3:0]});
    end
    `CHK(sync_word, 8'h34)
    host_u.run('{REGISTER_READ_COMMAND, 8'h09, 8'h44, z, z, z});
    `CHK({host_u.r[3], host_u.r[4]}, 16'h3a45)
    $display("test config done");
    host_u.run('{DIO_IRQ_COMMAND, 8'hff, 8'hff, z, 8'h01, z, 8'h04, z, 8'h05});
    ev = '0;
    ev.tx_done = 1'b1;
    pulse(ev);
    `CHK({tx_complete_flag, dio}, 4'b1101)
    ev = '0;
    ev.sync_valid = 1'b1;
    ev.sync_code = 3'b100;
    pulse(ev);
    `CHK({matched_sync_index, dio}, 6'b100111)
    host_u.run('{PACKET_STATUS_COMMAND, z, z, z, z, z});
    `CHK({host_u.r[0], host_u.r[2], host_u.r[3]}, 24'h5c0104)
    host_u.run('{IRQ_CLEAR_COMMAND, z, 8'h01});
    `CHK({tx_complete_flag, dio}, 4'b0110)
    host_u.run('{IRQ_STATUS_COMMAND, z, z});
    `CHK({host_u.r[0], host_u.r[1]}, 16'h0004)
    for (s = 0; s < 3; s++) begin
      ev.sync_code = 3'(s);
      pulse(ev);
      `CHK(matched_sync_index, 3'(s))
    end
    host_u.run('{IRQ_CLEAR_COMMAND, z, 8'h04});
    `CHK(dio, 3'b000)
    $display("test irq done");
    // a packet with the other iq sense while no rx flag is pending
    ev = '0;
    ev.rx_done = 1'b1;
    pulse(ev);
    for (k = 0; k < 3; k++) begin
      @(posedge clock);
      rx_wr_valid <= 1'b1;
      rx_wr_data <= 8'(8'h11 * (k + 1));
    end
    @(posedge clock);
    rx_wr_valid <= 1'b0;
    ev.pkt_iq_swapped = 1'b1;
    pulse(ev);
    ev.pkt_iq_swapped = 1'b0;
    pulse(ev);
    host_u.run('{RX_BUFFER_INFO_COMMAND, z, z});
    `CHK({host_u.r[0], host_u.r[1]}, 16'h0380)
    host_u.run('{BUFFER_READ_COMMAND, host_u.r[1], z, z, z, z});
    `CHK({host_u.r[2], host_u.r[3], host_u.r[4]}, 24'h112233)
    host_u.run('{BUFFER_WRITE_COMMAND, 8'h10, 8'ha5, 8'h5a});
    @(posedge clock);
    tx_rd_req <= 1'b1;
    tx_rd_idx <= 8'h01;
    @(posedge clock);
    tx_rd_req <= 1'b0;
    @(negedge clock);
    `CHK(tx_rd_data, 8'h5a)
    $display("test buffer done");
    summarize();
  end
endmodule
